//--- design/fbc_bw_regs.sv
/*
  filter bandwidth register bank: holds filter_control, bandwidth_gain_bias
  and fine_tune_setting, adopts coarse and fine codes on the apply bit, lets
  the calibration circuit fill the fine code in automatic mode, and shows the
  calibration result to the host over the serial port.
  assumes the analogue side gives a one-cycle cal_fine_valid with its code,
  and holds cal_result steady while it may be read.
*/
`timescale 1ns/1ps
`default_nettype none

module fbc_bw_regs (
  input  wire logic        mclk,           // system clock, 40 mhz
  input  wire logic        nrst,           // asynchronous reset, active low
  input  wire logic        spi_sck,        // serial clock
  input  wire logic        spi_cs_n,       // serial frame select, active low
  input  wire logic        spi_sdi,        // serial data in
  output var  logic        spi_sdo,        // serial data out
  output var  logic        spi_sdo_oe_n,   // sdo driven while low
  input  wire logic        cal_fine_valid, // calibration has a fine code
  input  wire logic [3:0]  cal_fine_code,  // fine code found by calibration
  input  wire logic [23:0] cal_result,     // rc calibration measurement
  output var  logic        rc_cal_en,      // rc calibration circuit enable
  output var  logic        auto_cal_en,    // automatic calibrated mode
  output var  logic [3:0]  coarse_bw,      // adopted coarse code, capacitors
  output var  logic [3:0]  fine_bw,        // adopted fine code, resistors
  output var  logic [6:0]  nominal_bw_mhz  // nominal corner of coarse_bw, 0 if none or if no apply since reset
);

  // ****************************************************************
  // serial port
  // ****************************************************************
  logic        wr_stb;                     // register write
  logic        rd_stb;                     // register read request
  logic [6:0]  reg_addr;                   // frame address
  logic [23:0] reg_wdata;                  // frame write data
  logic [23:0] reg_rdata;                  // read answer

  fbc_spi_slave u_spi (
    .mclk         (mclk),
    .nrst         (nrst),
    .spi_sck      (spi_sck),
    .spi_cs_n     (spi_cs_n),
    .spi_sdi      (spi_sdi),
    .spi_sdo      (spi_sdo),
    .spi_sdo_oe_n (spi_sdo_oe_n),
    .wr_stb       (wr_stb),
    .rd_stb       (rd_stb),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [23:0] ctrl_ff, nxt_ctrl;          // filter_control
  logic [23:0] bgb_ff, nxt_bgb;            // bandwidth_gain_bias
  logic [23:0] fts_ff, nxt_fts;            // fine_tune_setting
  logic [3:0]  coarse_ff, nxt_coarse;      // adopted coarse code
  logic [3:0]  fine_ff, nxt_fine;          // adopted fine code
  logic [6:0]  nom_ff, nxt_nom;            // nominal corner of the adopted code, zero until the first apply
  logic        wr_ctrl;                    // host writes filter_control
  logic        wr_bgb;                     // host writes bandwidth_gain_bias
  logic        wr_fts;                     // host writes fine_tune_setting
  logic        apply;                      // host asks to adopt the codes
  logic        cal_fill;                   // calibration writes the fine code

  assign wr_ctrl  = wr_stb & (reg_addr == fbc_pkg::REG_CTRL);
  assign wr_bgb   = wr_stb & (reg_addr == fbc_pkg::REG_BGB);
  assign wr_fts   = wr_stb & (reg_addr == fbc_pkg::REG_FTS);
  assign apply    = wr_ctrl & reg_wdata[fbc_pkg::CTRL_APPLY_BIT];
  assign cal_fill = cal_fine_valid & ctrl_ff[fbc_pkg::CTRL_AUTO_BIT];

  // next register values
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_bgb    = bgb_ff;
    nxt_fts    = fts_ff;
    nxt_coarse = coarse_ff;
    nxt_fine   = fine_ff;
    nxt_nom    = nom_ff;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wdata;
      // apply is a command, not a state, so it never reads back as one
      nxt_ctrl[fbc_pkg::CTRL_APPLY_BIT] = 1'b0;
    end
    if (wr_bgb) begin
      nxt_bgb = reg_wdata;
    end
    if (wr_fts) begin
      nxt_fts = reg_wdata;
    end
    // the calibration fill wins over a host write in the same cycle,
    // since the measured code is the one that makes the corner accurate
    if (cal_fill) begin
      nxt_fts[fbc_pkg::FINE_MSB:fbc_pkg::FINE_LSB] = cal_fine_code;
    end
    if (apply) begin
      // codes are adopted as they stand before this cycle's writes
      nxt_coarse = bgb_ff[fbc_pkg::COARSE_MSB:fbc_pkg::COARSE_LSB];
      nxt_fine   = fts_ff[fbc_pkg::FINE_MSB:fbc_pkg::FINE_LSB];
      // codes above the presets have no nominal corner and show zero
      if (nxt_coarse < fbc_pkg::COARSE_CODES) begin
        nxt_nom = fbc_pkg::NOM_BW_MHZ[nxt_coarse];
      end else begin
        nxt_nom = fbc_pkg::NOM_RST;
      end
    end
  end

  // register update
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff   <= fbc_pkg::CTRL_RST;
      bgb_ff    <= fbc_pkg::BGB_RST;
      fts_ff    <= fbc_pkg::FTS_RST;
      coarse_ff <= fbc_pkg::CODE_RST;
      fine_ff   <= fbc_pkg::CODE_RST;
      nom_ff    <= fbc_pkg::NOM_RST;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      bgb_ff    <= nxt_bgb;
      fts_ff    <= nxt_fts;
      coarse_ff <= nxt_coarse;
      fine_ff   <= nxt_fine;
      nom_ff    <= nxt_nom;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unmapped addresses read as zero; the result is only sampled with rd_stb
  always_comb begin
    case (reg_addr)
      fbc_pkg::REG_CTRL: reg_rdata = ctrl_ff;
      fbc_pkg::REG_BGB:  reg_rdata = bgb_ff;
      fbc_pkg::REG_FTS:  reg_rdata = fts_ff;
      fbc_pkg::REG_CAL:  reg_rdata = cal_result;
      default:           reg_rdata = 24'h000000;
    endcase
  end

  assign rc_cal_en      = ctrl_ff[fbc_pkg::CTRL_RC_CAL_BIT];
  assign auto_cal_en    = ctrl_ff[fbc_pkg::CTRL_AUTO_BIT];
  assign coarse_bw      = coarse_ff;
  assign fine_bw        = fine_ff;
  assign nominal_bw_mhz = nom_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // a host write to filter_control, one with the apply command, and any cycle without such a write
  sequence ctrl_wr_s;
    wr_stb && (reg_addr == fbc_pkg::REG_CTRL);
  endsequence

  sequence apply_wr_s;
    wr_stb && (reg_addr == fbc_pkg::REG_CTRL) && reg_wdata[fbc_pkg::CTRL_APPLY_BIT];
  endsequence

  sequence no_apply_s;
    !(wr_stb && (reg_addr == fbc_pkg::REG_CTRL) && reg_wdata[fbc_pkg::CTRL_APPLY_BIT]);
  endsequence

  coarse_take_a: assert property (apply_wr_s |=> coarse_bw == $past(bgb_ff[9:6]))
    else $error("coarse code not adopted from bits 9:6");

  fine_take_a: assert property (apply_wr_s |=> fine_bw == $past(fts_ff[3:0]))
    else $error("fine code not adopted from bits 3:0");

  apply_hold_a: assert property (no_apply_s |=> $stable(coarse_bw) && $stable(fine_bw))
    else $error("codes changed without the apply bit");

  preset_14_a: assert property (
    (apply_wr_s and (bgb_ff[9:6] == 4'h3)) |=> nominal_bw_mhz == 7'h0e)
    else $error("coarse code 0011 did not give 14 mhz");

  auto_fill_a: assert property ((cal_fine_valid && auto_cal_en) |=> fts_ff[3:0] == $past(cal_fine_code))
    else $error("calibration did not fill the fine code");

  manual_keep_a: assert property (
    (!auto_cal_en && !(wr_stb && reg_addr == fbc_pkg::REG_FTS)) |=> $stable(fts_ff))
    else $error("fine code changed outside a host write in manual mode");

  cal_read_a: assert property (
    (rd_stb && reg_addr == fbc_pkg::REG_CAL) |=> spi_sdo == $past(cal_result[23]))
    else $error("calibration result not returned");

  cal_enable_a: assert property (ctrl_wr_s |=>
    (rc_cal_en == $past(reg_wdata[fbc_pkg::CTRL_RC_CAL_BIT])) ##1 ($stable(rc_cal_en) || wr_stb))
    else $error("rc calibration enable does not follow bit 1");

  // a plain write must land whole, or the host reads back something else
  coarse_write_a: assert property (
    (wr_stb && reg_addr == fbc_pkg::REG_BGB) |=> bgb_ff == $past(reg_wdata))
    else $error("bandwidth_gain_bias write did not land");

  fine_write_a: assert property (
    (wr_stb && reg_addr == fbc_pkg::REG_FTS && !cal_fill) |=> fts_ff == $past(reg_wdata))
    else $error("fine_tune_setting write did not land");

  apply_clear_a: assert property (
    ctrl_wr_s |=> !ctrl_ff[fbc_pkg::CTRL_APPLY_BIT])
    else $error("apply bit stayed set after the write");

  nom_none_a: assert property (
    (apply_wr_s and (bgb_ff[9:6] >= fbc_pkg::COARSE_CODES)) |=> nominal_bw_mhz == 7'h00)
    else $error("code above the presets showed a corner");

  rc_cal_hold_a: assert property (
    !(wr_stb && reg_addr == fbc_pkg::REG_CTRL) |=> $stable(rc_cal_en) && $stable(auto_cal_en))
    else $error("control bits moved without a control write");

endmodule

`default_nettype wire

//--- design/fbc_pkg.sv
/*
  constants shared by the filter bandwidth register bank and its serial port:
  register addresses, field positions, reset values, frame counts and the
  nominal coarse bandwidth table.
  assumes nothing of its surroundings; it is compiled before every other file.
*/
package fbc_pkg;

  // ****************************************************************
  // widths and register addresses
  // ****************************************************************
  localparam int          ADDR_W      = 7;         // register address width
  localparam int          DATA_W      = 24;        // register data width
  localparam logic [6:0]  REG_CTRL    = 7'h01;     // filter_control
  localparam logic [6:0]  REG_BGB     = 7'h02;     // bandwidth_gain_bias
  localparam logic [6:0]  REG_FTS     = 7'h03;     // fine_tune_setting
  localparam logic [6:0]  REG_CAL     = 7'h09;     // rc calibration result

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          CTRL_RC_CAL_BIT = 1;     // rc calibration enable
  localparam int          CTRL_APPLY_BIT  = 4;     // adopt coarse and fine codes
  localparam int          CTRL_AUTO_BIT   = 6;     // automatic calibrated mode
  localparam int          COARSE_MSB      = 9;     // coarse code in bandwidth_gain_bias
  localparam int          COARSE_LSB      = 6;
  localparam int          FINE_MSB        = 3;     // fine code in fine_tune_setting
  localparam int          FINE_LSB        = 0;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [23:0] CTRL_RST    = 24'h000000;
  localparam logic [23:0] BGB_RST     = 24'h000000;
  localparam logic [23:0] FTS_RST     = 24'h000000;
  localparam logic [3:0]  CODE_RST    = 4'h0;
  localparam logic [6:0]  NOM_RST     = 7'h00;

  // ****************************************************************
  // serial frame: 8 header bits {read, address[6:0]} then 24 data bits
  // ****************************************************************
  localparam logic [4:0]  HDR_LAST    = 5'h07;     // count at the last header bit
  localparam logic [4:0]  FRAME_LAST  = 5'h1f;     // count at the last data bit
  localparam logic [4:0]  CNT_RST     = 5'h00;

  // ****************************************************************
  // nominal coarse bandwidth in mhz for each coarse code
  // ****************************************************************
  localparam logic [3:0]  COARSE_CODES = 4'h9;     // codes 0 to 8 are presets
  localparam logic [6:0]  NOM_BW_MHZ [0:8] = '{7'h05, 7'h07, 7'h0a, 7'h0e, 7'h14,
                                               7'h1c, 7'h28, 7'h32, 7'h48};

endpackage

//--- design/fbc_spi_slave.sv
/*
  serial port slave of the filter bandwidth register bank: turns 32-bit frames
  into register write strobes and read requests, and shifts read data out.
  assumes sck, cs_n and sdi are synchronous to mclk and sck runs at most at
  mclk/4, so each sck level lasts at least two mclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module fbc_spi_slave (
  input  wire logic        mclk,         // system clock
  input  wire logic        nrst,         // asynchronous reset, active low
  input  wire logic        spi_sck,      // serial clock, data sampled on rise
  input  wire logic        spi_cs_n,     // frame select, active low
  input  wire logic        spi_sdi,      // serial data in, msb first
  output var  logic        spi_sdo,      // serial data out
  output var  logic        spi_sdo_oe_n, // sdo driven while low
  output var  logic        wr_stb,       // one-cycle write strobe
  output var  logic        rd_stb,       // one-cycle read request
  output var  logic [6:0]  reg_addr,     // address of the current frame
  output var  logic [23:0] reg_wdata,    // write data, valid with wr_stb
  input  wire logic [23:0] reg_rdata     // read data, sampled with rd_stb
);

  // ****************************************************************
  // frame state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,                     // no frame open
    ST_HDR  = 2'b01,                     // taking the header
    ST_DATA = 2'b10,                     // taking or giving the data word
    ST_DONE = 2'b11                      // frame complete, extra edges ignored
  } fbc_spi_e;

  fbc_spi_e     state_ff, nxt_state;     // frame state
  logic         sck_ff;                  // sck one cycle late, for edge finding
  logic [4:0]   cnt_ff, nxt_cnt;         // bits taken so far
  logic [30:0]  sh_ff, nxt_sh;           // incoming bits
  logic [23:0]  tx_ff, nxt_tx;           // outgoing read word
  logic         rnw_ff, nxt_rnw;         // frame is a read
  logic [6:0]   addr_ff, nxt_addr;       // frame address
  logic         wr_ff, nxt_wr;           // write strobe
  logic         rd_ff, nxt_rd;           // read request
  logic [23:0]  wdata_ff, nxt_wdata;     // write word
  logic         sck_rise;                // sck went high
  logic         sck_fall;                // sck went low
  logic [7:0]   hdr;                     // header as it completes

  assign sck_rise = spi_sck & ~sck_ff;
  assign sck_fall = ~spi_sck & sck_ff;
  assign hdr      = {sh_ff[6:0], spi_sdi};

  // next frame state; cs_n high closes any frame at once
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_tx    = tx_ff;
    nxt_rnw   = rnw_ff;
    nxt_addr  = addr_ff;
    nxt_wr    = 1'b0;
    nxt_rd    = 1'b0;
    nxt_wdata = wdata_ff;
    if (rd_ff) begin
      nxt_tx = reg_rdata;                // the bank answers in the request cycle
    end
    if (spi_cs_n) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = fbc_pkg::CNT_RST;
    end else begin
      case (state_ff)
        ST_IDLE, ST_HDR: begin
          nxt_state = ST_HDR;
          if (sck_rise) begin
            nxt_sh  = {sh_ff[29:0], spi_sdi};
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == fbc_pkg::HDR_LAST) begin
              nxt_state = ST_DATA;
              nxt_rnw   = hdr[7];
              nxt_addr  = hdr[6:0];
              nxt_rd    = hdr[7];        // fetch before the first falling edge
            end
          end
        end
        ST_DATA: begin
          if (sck_rise) begin
            nxt_sh  = {sh_ff[29:0], spi_sdi};
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == fbc_pkg::FRAME_LAST) begin
              nxt_state = ST_DONE;
              nxt_wr    = ~rnw_ff;
              nxt_wdata = {sh_ff[22:0], spi_sdi};
            end
          end
          if (sck_fall && rnw_ff && !rd_ff) begin
            nxt_tx = {tx_ff[22:0], 1'b0};
          end
        end
        ST_DONE: begin
          nxt_state = ST_DONE;           // long frames do not wrap around
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // frame registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      sck_ff   <= 1'b0;
      cnt_ff   <= fbc_pkg::CNT_RST;
      sh_ff    <= 31'h00000000;
      tx_ff    <= 24'h000000;
      rnw_ff   <= 1'b0;
      addr_ff  <= 7'h00;
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
      wdata_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      sck_ff   <= spi_sck;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      tx_ff    <= nxt_tx;
      rnw_ff   <= nxt_rnw;
      addr_ff  <= nxt_addr;
      wr_ff    <= nxt_wr;
      rd_ff    <= nxt_rd;
      wdata_ff <= nxt_wdata;
    end
  end

  assign spi_sdo      = tx_ff[23];
  assign spi_sdo_oe_n = ~((state_ff == ST_DATA) & rnw_ff & ~spi_cs_n);
  assign wr_stb       = wr_ff;
  assign rd_stb       = rd_ff;
  assign reg_addr     = addr_ff;
  assign reg_wdata    = wdata_ff;

endmodule

`default_nettype wire

//--- verification/fbc_spi_host.sv
/*
  host controller model for the filter bandwidth register bank: sends one
  32-bit serial frame {rnw, address, data} per call of xfer, msb first.
  assumes the bank samples sck on mclk and reads sdi on sck rise.
*/
`timescale 1ns/1ps
`default_nettype none

module fbc_spi_host (
  input  wire logic mclk,         // system clock
  input  wire logic spi_sdo,      // serial data from the bank
  input  wire logic spi_sdo_oe_n, // low while the bank drives sdo
  output var  logic spi_sck,      // serial clock, idle low
  output var  logic spi_cs_n,     // frame select, active low
  output var  logic spi_sdi       // serial data to the bank
);
  // ****************************************************************
  // wire level of sdo
  // ****************************************************************
  // released line shows the inverse, so a stale bit can never pass
  wire logic sdo_line = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;

  // idle levels from time zero; sck stands still outside frames
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end

  // ****************************************************************
  // one frame; nbits below 32 drops cs_n early to abort it
  // ****************************************************************
  // sck lasts 3 mclk low and 4 mclk high, above the 2 and 3 cycle minimums
  task automatic xfer(input logic rnw, input logic [6:0] addr, input logic [23:0] data,
                      input int nbits, output logic [23:0] q);
    logic [31:0] frame;
    frame = {rnw, addr, data};
    q = 24'h000000;
    @(posedge mclk);
    spi_cs_n <= 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      @(posedge mclk);
      // the bank shifts sdo one edge after it sees a fall, so the bit
      // standing now is the one due before this fall moves it on
      q = {q[22:0], sdo_line};
      spi_sck <= 1'b0;
      spi_sdi <= frame[i];
      repeat (3) @(posedge mclk);
      spi_sck <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    @(posedge mclk);
    spi_sck <= 1'b0;
    repeat (2) @(posedge mclk);
    spi_cs_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

//--- verification/tb_top.sv
/*
  self-checking bench of the filter bandwidth register bank: frames from the
  host model, calibration codes driven here, outputs compared after each step.
  assumes the bank and the host model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        mclk, nrst;          // clock and reset
  logic        cal_fine_valid;      // calibration offers a code
  logic [3:0]  cal_fine_code;       // offered fine code
  logic [23:0] cal_result;          // calibration measurement
  wire logic   spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  wire logic   rc_cal_en, auto_cal_en;
  wire logic [3:0] coarse_bw, fine_bw;
  wire logic [6:0] nominal_bw_mhz;
  int          fail_count, tests_run, cycles;
  logic [23:0] q;                   // read data
  // nominal corner per coarse code, none above code 8
  logic [6:0]  nom_exp [0:15] = '{7'h05, 7'h07, 7'h0a, 7'h0e, 7'h14, 7'h1c, 7'h28,
                                 7'h32, 7'h48, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
                                 7'h00, 7'h00};

  fbc_bw_regs fbc_bw_regs_inst (.mclk(mclk), .nrst(nrst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .cal_fine_valid(cal_fine_valid),
    .cal_fine_code(cal_fine_code), .cal_result(cal_result), .rc_cal_en(rc_cal_en),
    .auto_cal_en(auto_cal_en), .coarse_bw(coarse_bw), .fine_bw(fine_bw),
    .nominal_bw_mhz(nominal_bw_mhz));
  fbc_spi_host fbc_spi_host_inst (.mclk(mclk), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi));

  // 40 mhz clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [23:0] dummy;
    fbc_spi_host_inst.xfer(1'b0, a, d, 32, dummy);
  endtask

  task automatic rd(input logic [6:0] a);
    fbc_spi_host_inst.xfer(1'b1, a, 24'h000000, 32, q);
  endtask

  // let the edge's updates land before looking
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask

  // one-cycle calibration offer
  task automatic offer(input logic [3:0] c);
    @(posedge mclk);
    cal_fine_valid <= 1'b1;
    cal_fine_code  <= c;
    @(posedge mclk);
    cal_fine_valid <= 1'b0;
    settle();
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    settle();
    check({rc_cal_en, auto_cal_en, coarse_bw, fine_bw, nominal_bw_mhz}, 24'h0, "idle outs");
    check(spi_sdo_oe_n, 1'b1, "sdo released");
    rd(7'h01); check(q, 24'h0, "ctrl reset");
    rd(7'h02); check(q, 24'h0, "bgb reset");
    rd(7'h03); check(q, 24'h0, "fts reset");
  endtask

  // 13 mhz by hand: nearest preset 14, ratio 0.93 gives fine 0100
  task automatic t_apply;
    wr(7'h02, 24'h0000c1);
    wr(7'h03, 24'h000004);
    settle();
    check(coarse_bw, 4'h0, "coarse early");
    check(fine_bw, 4'h0, "fine early");
    rd(7'h02); check(q, 24'h0000c1, "bgb read");
    rd(7'h03); check(q, 24'h000004, "fts read");
    wr(7'h01, 24'h000010);
    settle();
    check(coarse_bw, 4'h3, "coarse applied");
    check(fine_bw, 4'h4, "fine applied");
    check(nominal_bw_mhz, 7'h0e, "14 mhz");
    rd(7'h01); check(q, 24'h000000, "apply clears");
    wr(7'h02, 24'h000200);
    wr(7'h01, 24'h000010);
    settle();
    check(coarse_bw, 4'h8, "back to back");
  endtask

  // automatic mode: host keeps coarse preset 8 and applies, calibration fills fine code
  task automatic t_auto;
    wr(7'h01, 24'h000042);
    settle();
    check(rc_cal_en, 1'b1, "cal enable");
    check(auto_cal_en, 1'b1, "auto mode");
    offer(4'ha);
    rd(7'h03); check(q, 24'h00000a, "cal fill");
    check(fine_bw, 4'h4, "fill held");
    wr(7'h01, 24'h000052);
    settle();
    check(fine_bw, 4'ha, "fill applied");
    check(coarse_bw, 4'h8, "coarse kept");
    wr(7'h01, 24'h000000);
    offer(4'h3);
    rd(7'h03); check(q, 24'h00000a, "no fill manual");
    check(rc_cal_en, 1'b0, "cal off");
  endtask

  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      wr(7'h02, {14'h0, c[3:0], 6'h00});
      wr(7'h01, 24'h000010);
      settle();
      check(coarse_bw, c[3:0], "coarse code");
      check(nominal_bw_mhz, nom_exp[c], "preset corner");
    end
  endtask

  task automatic t_misc;
    @(posedge mclk);
    cal_result <= 24'h5a3c96;
    rd(7'h09); check(q, 24'h5a3c96, "cal result");
    check(spi_sdo_oe_n, 1'b1, "sdo off after");
    wr(7'h09, 24'h123456);
    rd(7'h09); check(q, 24'h5a3c96, "cal read only");
    rd(7'h05); check(q, 24'h000000, "unmapped");
    fbc_spi_host_inst.xfer(1'b0, 7'h02, 24'h000040, 20, q);
    rd(7'h02); check(q, 24'h0003c0, "aborted frame");
  endtask

  // mid-run reset, then the host reloads the codes it kept from calibration
  task automatic t_rearm;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    check({rc_cal_en, auto_cal_en, coarse_bw, fine_bw, nominal_bw_mhz}, 24'h0, "rearm outs");
    rd(7'h03); check(q, 24'h0, "fts cleared");
    wr(7'h03, 24'h00000a);
    wr(7'h02, 24'h000200);
    wr(7'h01, 24'h000010);
    settle();
    check({coarse_bw, fine_bw}, 8'h8a, "kept codes");
    check(nominal_bw_mhz, 7'h48, "kept corner");
  endtask

  // ****************************************************************
  // main sequence and time limit
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    cal_fine_valid = 1'b0;
    cal_fine_code = 4'h0;
    cal_result = 24'h000000;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_apply();
    t_auto();
    t_codes();
    t_misc();
    t_rearm();
    summarize();
  end

  // about 60 frames of 230 cycles fit well inside this ceiling
  initial cycles = 0;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end
endmodule

`default_nettype wire
